// ### ewc_map.vh
// Constants for the single-wire EPROM write host: timing counts and CRC layout.
// Assumes a 250 MHz core clock; times are in microseconds and a cycles-per-us
// factor turns them into core_clk counts.
`ifndef EWC_MAP_VH
`define EWC_MAP_VH

// Clock period in ns, and core cycles per microsecond at that period.
`define EWC_CLK_NS 4
`define EWC_US_CYC 20'h000fa
// Reset low and reset high (recovery) times in us (480).
`define EWC_RST_LOW_US 20'h001e0
`define EWC_RST_HIGH_US 20'h001e0
// Write-one low time, write-zero low time, slot length, in us (6, 60, 70).
`define EWC_LOW1_US 20'h00006
`define EWC_LOW0_US 20'h0003c
`define EWC_SLOT_US 20'h00046
// Read strobe low time, late sample point, valid window, in us (1, 13, 15).
`define EWC_RD_LOW_US 20'h00001
`define EWC_RD_SAMPLE_US 20'h0000d
`define EWC_RD_WINDOW_US 20'h0000f
// Presence sample point after release, in us (70).
`define EWC_PRES_US 20'h00046
// Program pulse width in us (480).
`define EWC_PROG_US 20'h001e0
// CRC-16 polynomial x^16+x^15+x^2+1 (reflected form) and clear value.
`define EWC_CRC_POLY 16'ha001
`define EWC_CRC_INIT 16'h0000
// Mask keeping the three lower bits of the high target-address byte.
`define EWC_ADDR_HI_KEEP 8'h07
// Write memory command code, a plain default.
`define EWC_CMD_WRITE 8'h0f

`endif

// ### ewc_crc16.v
// CRC-16 engine for the host: clear, load, or shift one byte LSB first.
// Assumes the caller gives at most one of clear, load or shift per cycle.
module ewc_crc16 (
	input wire core_clk,
	input wire rstn,
	input wire clr,
	input wire load,
	input wire [15:0] load_val,
	input wire shift,
	input wire [7:0] din,
	output reg [15:0] crc_q
);
`include "ewc_map.vh"

	reg [15:0] c;
	integer i;

	////////////////////////////////////////////////////////////////////////////
	// Byte-wide unrolled LFSR so a whole byte folds in one clock.
	always @* begin
		c = crc_q;
		for (i = 0; i < 8; i = i + 1) begin
			if (c[0] ^ din[i])
				c = (c >> 1) ^ `EWC_CRC_POLY;
			else
				c = c >> 1;
		end
	end

	// Clear starts a sequence, load seeds with the incremented address.
	always @(posedge core_clk) begin
		if (!rstn)
			crc_q <= `EWC_CRC_INIT;
		else if (clr)
			crc_q <= `EWC_CRC_INIT;
		else if (load)
			crc_q <= load_val;
		else if (shift)
			crc_q <= c;
	end
endmodule // ewc_crc16

// ### ewc_host.v
// Host controller writing EPROM bytes over a single open-drain data wire.
// Assumes the wire is pulled up outside; the user gives command and data.
// Operation
// - Host alone decides on CRC mismatch.
// - Low supply: host sets high-address top bits.
// - Host waits reset-high time before next action.
// - Host samples read bit late, inside 15 us.
`include "ewc_map.vh"

// US_CYC is core cycles per microsecond; a bench may lower it to shorten runs.
module ewc_host #(
	parameter [19:0] US_CYC = `EWC_US_CYC
) (
	input wire core_clk,
	input wire rstn,
	input wire start,
	input wire first,
	input wire low_vpup,
	input wire [7:0] cmd,
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire abort_on_bad,
	input wire dq_i,
	output reg dq_o,
	output reg dq_oe,
	output reg prog_en,
	output wire busy,
	output reg done_q,
	output reg crc_ok_q,
	output reg presence_q
);

	localparam [3:0] S_IDLE = 4'h0, S_RLOW = 4'h1, S_RHIGH = 4'h2, S_LOAD = 4'h3,
		S_TX = 4'h4, S_RX = 4'h5, S_CHK = 4'h6, S_PROG = 4'h7, S_FIN = 4'h8;
	localparam [19:0] C_RLOW = `EWC_RST_LOW_US * US_CYC;
	localparam [19:0] C_RHIGH = `EWC_RST_HIGH_US * US_CYC;
	localparam [19:0] C_PRES = `EWC_PRES_US * US_CYC;
	localparam [19:0] C_LOW1 = `EWC_LOW1_US * US_CYC;
	localparam [19:0] C_LOW0 = `EWC_LOW0_US * US_CYC;
	localparam [19:0] C_SLOT = `EWC_SLOT_US * US_CYC;
	localparam [19:0] C_RDLOW = `EWC_RD_LOW_US * US_CYC;
	localparam [19:0] C_RDSMP = `EWC_RD_SAMPLE_US * US_CYC;
	localparam [19:0] C_PROG = `EWC_PROG_US * US_CYC;

	reg [3:0] st_q;
	reg [19:0] tmr_q;
	reg [39:0] sh_q;
	reg [5:0] nbits_q;
	reg [3:0] nrx_q;
	reg [15:0] rx_q;
	reg [15:0] addr_q;
	reg seq_first_q;
	reg [7:0] data_q;
	reg crc_clr, crc_ld, crc_sh;
	reg [7:0] crc_din;
	wire [15:0] crc_val;
	wire [7:0] addr_hi_tx;
	wire [7:0] addr_hi_dev;
	wire bit_now;

	////////////////////////////////////////////////////////////////////////////
	// High address byte: raise top bits when pull-up is low; the device will
	// mask them back, so the local CRC uses the masked value.
	assign addr_hi_tx = low_vpup ? (addr[15:8] | ~`EWC_ADDR_HI_KEEP) : addr[15:8];
	assign addr_hi_dev = addr[15:8] & `EWC_ADDR_HI_KEEP;
	assign busy = (st_q != S_IDLE);
	assign bit_now = sh_q[0];

	// Local CRC model of what the device computes.
	ewc_crc16 u_crc (
		.core_clk(core_clk),
		.rstn(rstn),
		.clr(crc_clr),
		.load(crc_ld),
		.load_val(addr_q),
		.shift(crc_sh),
		.din(crc_din),
		.crc_q(crc_val)
	);

	// CRC steering: first byte folds four bytes over four cycles in S_LOAD.
	always @* begin
		crc_clr = 1'b0;
		crc_ld = 1'b0;
		crc_sh = 1'b0;
		crc_din = 8'h00;
		if (st_q == S_LOAD) begin
			crc_sh = 1'b1;
			case (tmr_q[1:0])
			2'd0: crc_din = cmd;
			2'd1: crc_din = addr_q[7:0];
			2'd2: crc_din = addr_q[15:8];
			default: crc_din = data_q;
			endcase
			if (!seq_first_q) begin
				crc_sh = (tmr_q[1:0] == 2'd3);
				crc_ld = (tmr_q[1:0] == 2'd0);
			end
		end else if (st_q == S_IDLE && start) begin
			crc_clr = first;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequencer: reset, send bytes, read CRC, check, program pulse.
	always @(posedge core_clk) begin
		if (!rstn) begin
			st_q <= S_IDLE;
			tmr_q <= 20'h00000;
			sh_q <= 40'h0000000000;
			nbits_q <= 6'h00;
			nrx_q <= 4'h0;
			rx_q <= 16'h0000;
			addr_q <= 16'h0000;
			seq_first_q <= 1'b0;
			data_q <= 8'h00;
			dq_oe <= 1'b0;
			prog_en <= 1'b0;
			done_q <= 1'b0;
			crc_ok_q <= 1'b0;
			presence_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			tmr_q <= tmr_q + 20'h00001;
			case (st_q)
			S_IDLE: begin
				tmr_q <= 20'h00000;
				if (start) begin
					seq_first_q <= first;
					data_q <= wdata;
					if (first) begin
						addr_q <= {addr_hi_dev, addr[7:0]};
						sh_q <= {wdata, addr_hi_tx, addr[7:0], cmd, 8'h00};
						st_q <= S_RLOW;
					end else begin
						addr_q <= addr_q + 16'h0001;
						sh_q <= {32'h00000000, wdata};
						st_q <= S_LOAD;
					end
				end
			end
			S_RLOW: begin
				dq_oe <= 1'b1;
				// Pulled from the tmr_q == 0 edge, so the full count is held.
				if (tmr_q == C_RLOW) begin
					dq_oe <= 1'b0;
					tmr_q <= 20'h00000;
					st_q <= S_RHIGH;
				end
			end
			S_RHIGH: begin
				if (tmr_q == C_PRES)
					presence_q <= ~dq_i;
				// Full reset-high time passes before any slot starts.
				if (tmr_q == C_RHIGH - 20'h00001) begin
					tmr_q <= 20'h00000;
					st_q <= S_LOAD;
				end
			end
			S_LOAD: begin
				if (tmr_q[1:0] == 2'd3) begin
					tmr_q <= 20'h00000;
					nbits_q <= seq_first_q ? 6'd32 : 6'd8;
					if (seq_first_q)
						sh_q <= {8'h00, sh_q[39:8]};
					st_q <= S_TX;
				end
			end
			S_TX: begin
				dq_oe <= (tmr_q < (bit_now ? C_LOW1 : C_LOW0));
				if (tmr_q == C_SLOT - 20'h00001) begin
					tmr_q <= 20'h00000;
					sh_q <= {1'b0, sh_q[39:1]};
					nbits_q <= nbits_q - 6'd1;
					if (nbits_q == 6'd1) begin
						nrx_q <= 4'd15;
						st_q <= S_RX;
					end
				end
			end
			S_RX: begin
				dq_oe <= (tmr_q < C_RDLOW);
				// Late sample, still within the device's valid window.
				if (tmr_q == C_RDSMP)
					rx_q <= {dq_i, rx_q[15:1]};
				if (tmr_q == C_SLOT - 20'h00001) begin
					tmr_q <= 20'h00000;
					nrx_q <= nrx_q - 4'd1;
					if (nrx_q == 4'd0)
						st_q <= S_CHK;
				end
			end
			S_CHK: begin
				// CRC arrives complemented; compare against the inverse.
				crc_ok_q <= (rx_q == ~crc_val);
				tmr_q <= 20'h00000;
				// Mismatch policy belongs to the host, not the device.
				if ((rx_q == ~crc_val) || !abort_on_bad)
					st_q <= S_PROG;
				else
					st_q <= S_FIN;
			end
			S_PROG: begin
				prog_en <= 1'b1;
				// The pulse must not fall short of its minimum width.
				if (tmr_q == C_PROG) begin
					prog_en <= 1'b0;
					st_q <= S_FIN;
				end
			end
			S_FIN: begin
				done_q <= 1'b1;
				st_q <= S_IDLE;
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end

	// Open drain: only ever drive low.
	always @(posedge core_clk) begin
		if (!rstn)
			dq_o <= 1'b0;
	end
endmodule // ewc_host

// ### ewc_host_assertions.sv
// Port checker for the single-wire EPROM write host.
// Assumes it is bound to ewc_host and the wire is pulled up outside.
`include "ewc_map.vh"
module ewc_chk #(
	parameter int US_CYC = `EWC_US_CYC
) (
	input wire core_clk,
	input wire rstn,
	input wire start,
	input wire abort_on_bad,
	input wire dq_o,
	input wire dq_oe,
	input wire prog_en,
	input wire busy,
	input wire done_q,
	input wire crc_ok_q
);
	// Expected pull, reset-high and program pulse lengths in cycles, from the microsecond figures.
	localparam int L_RD = `EWC_RD_LOW_US * US_CYC;
	localparam int L_ONE = `EWC_LOW1_US * US_CYC;
	localparam int L_ZERO = `EWC_LOW0_US * US_CYC;
	localparam int L_RST = `EWC_RST_LOW_US * US_CYC;
	localparam int L_GAP = `EWC_RST_HIGH_US * US_CYC;
	localparam int L_PROG = `EWC_PROG_US * US_CYC;
	logic [19:0] hi_q, lo_q, pg_q;
	logic long_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Pull and release lengths; a long pull marks a bus reset.
	always @(posedge core_clk) begin
		hi_q <= (rstn && dq_oe) ? hi_q + 20'h1 : 20'h0;
		lo_q <= (rstn && !dq_oe) ? lo_q + 20'h1 : 20'h0;
		pg_q <= (rstn && prog_en) ? pg_q + 20'h1 : 20'h0;
		if (!rstn) long_q <= 1'b0;
		else if (!dq_oe && hi_q != 20'h0) long_q <= hi_q >= L_RST;
	end
	////////////////////////////////////////////////////////////////////////////
	property p_drv; dq_o == 1'b0; endproperty
	a_drv: assert property (p_drv) else $error("wire driven high");
	property p_take; start && !busy |=> busy; endproperty
	a_take: assert property (p_take) else $error("start not taken");
	property p_done; done_q |=> !done_q; endproperty
	a_done: assert property (p_done) else $error("done longer than one cycle");
	property p_prog; prog_en |-> !dq_oe; endproperty
	a_prog: assert property (p_prog) else $error("wire pulled during program");
	property p_abort; $rose(prog_en) |-> crc_ok_q || !abort_on_bad; endproperty
	a_abort: assert property (p_abort) else $error("program after bad check");
	property p_len; $fell(dq_oe) |-> hi_q == L_RD || hi_q == L_ONE ||
		hi_q == L_ZERO || hi_q == L_RST; endproperty
	a_len: assert property (p_len) else $error("bad pull length");
	property p_gap; $rose(dq_oe) && long_q |-> lo_q >= L_GAP; endproperty
	a_gap: assert property (p_gap) else $error("reset high time short");
	property p_end; done_q |-> !prog_en && !dq_oe; endproperty
	a_end: assert property (p_end) else $error("done while driving");
	// A short pulse could leave the cell half programmed.
	property p_pulse; $fell(prog_en) |-> pg_q == L_PROG; endproperty
	a_pulse: assert property (p_pulse) else $error("program pulse length wrong");
endmodule // ewc_chk

bind ewc_host ewc_chk #(.US_CYC(US_CYC)) ewc_chk_i (.core_clk(core_clk), .rstn(rstn),
	.start(start),
	.abort_on_bad(abort_on_bad), .dq_o(dq_o), .dq_oe(dq_oe), .prog_en(prog_en),
	.busy(busy), .done_q(done_q), .crc_ok_q(crc_ok_q));

// ### ewc_dev_model.sv
// Behavioural add-only EPROM on the data wire: presence, write bytes, CRC.
// Assumes a pulled-up wire; bad flips the first CRC bit sent.
// US_NS is the length of one microsecond in ns, matched to the host's time base.
`include "ewc_map.vh"
module ewc_dev_model #(
	parameter real US_NS = 1000.0
) (
	input wire dq,
	input wire bad,
	output logic dev_low,
	output logic r7_err
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] c, a;
	logic [7:0] b;
	int n, rd, i;
	realtime t0, tr;
	// Each falling edge opens a slot; the device keeps going on a bad check.
	initial begin
		dev_low = 0;
		r7_err = 0;
		rd = 0;
		tr = -1.0e6;
		forever begin
			@(negedge dq);
			t0 = $realtime;
			if (t0 - tr < `EWC_RST_HIGH_US * US_NS) r7_err = 1;
			if (rd > 0) begin
				dev_low = c[16 - rd] ^ (bad && rd == 16);
				#(`EWC_RD_WINDOW_US * US_NS) dev_low = 0;
				rd--;
				if (rd == 0) begin
					a++;
					c = a;
					n = 24;
				end
			end else begin
				#(30 * US_NS) b = {dq, b[7:1]};
				n++;
				wait (dq);
				if ($realtime - t0 >= `EWC_RST_LOW_US * US_NS) begin
					tr = $realtime;
					#(30 * US_NS) dev_low = 1;
					#(120 * US_NS) dev_low = 0;
					c = 16'h0;
					n = 0;
				end else if (n % 8 == 0) begin
					if (n == 24) b[7:3] = 5'h0;
					if (n == 16) a[7:0] = b;
					if (n == 24) a[15:8] = b;
					for (i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? `EWC_CRC_POLY : 16'h0);
					if (n == 32) rd = 16;
				end
			end
		end
	end
endmodule // ewc_dev_model

// ### tb.sv
// Self-checking bench: host writes bytes to the device model in two sequences.
// Assumes the wire is open drain with a pull-up.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rstn = 0, start = 0, first = 0, low_vpup = 0, abort_on_bad = 0;
	logic bad = 0, prog_seen = 0;
	logic [7:0] wdata = 8'h00;
	wire dq_o, dq_oe, prog_en, busy, done_q, crc_ok_q, presence_q, dev_low, r7_err;
	wire dq = !(dq_oe || dev_low); // Released wire floats high.
	int error_cnt = 0, comparisons = 0;
	always #2 core_clk = !core_clk;
	// Both sides use a short time base, one microsecond being four cycles (16 ns),
	// so the run stays short; the ratios between all times are unchanged.
	ewc_host #(.US_CYC(20'h00004)) ewc_host_i (.core_clk(core_clk), .rstn(rstn),
		.start(start), .first(first),
		.low_vpup(low_vpup), .cmd(8'h0f), .addr(16'h0123), .wdata(wdata),
		.abort_on_bad(abort_on_bad), .dq_i(dq), .dq_o(dq_o), .dq_oe(dq_oe),
		.prog_en(prog_en), .busy(busy), .done_q(done_q), .crc_ok_q(crc_ok_q),
		.presence_q(presence_q));
	ewc_dev_model #(.US_NS(16.0)) ewc_dev_model_i (.dq(dq), .bad(bad), .dev_low(dev_low),
		.r7_err(r7_err));
	////////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic seen, input logic exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task end_of_test;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One byte transfer; the bound covers reset, slots and program pulse.
	task run(input logic f, input logic [7:0] d);
		int i;
		@(negedge core_clk);
		first = f;
		wdata = d;
		start = 1;
		@(negedge core_clk);
		start = 0;
		prog_seen = 0;
		for (i = 0; i < 30000 && done_q !== 1'b1; i++) begin
			@(negedge core_clk);
			prog_seen |= prog_en === 1'b1;
		end
		if (done_q !== 1'b1) begin
			error_cnt++;
			end_of_test;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	// First byte with the low-supply high address bits set.
	task t_first;
		low_vpup = 1;
		abort_on_bad = 1;
		run(1'b1, 8'h5a);
		check("presence", presence_q, 1'b1);
		check("crc_first", crc_ok_q, 1'b1);
		check("prog_first", prog_seen, 1'b1);
	endtask
	// Next byte uses the loaded incremented address.
	task t_next;
		low_vpup = 0;
		run(1'b0, 8'ha5);
		check("crc_next", crc_ok_q, 1'b1);
		check("prog_next", prog_seen, 1'b1);
	endtask
	// A corrupted CRC must stop the pulse only by the host's choice.
	task t_bad;
		bad = 1;
		run(1'b0, 8'hc3);
		check("crc_bad", crc_ok_q, 1'b0);
		check("prog_bad", prog_seen, 1'b0);
		abort_on_bad = 0;
		run(1'b0, 8'h96);
		check("crc_keep", crc_ok_q, 1'b0);
		check("prog_keep", prog_seen, 1'b1);
		bad = 0;
		abort_on_bad = 1;
	endtask
	// A second sequence repeats the bus reset without raised address bits.
	task t_again;
		low_vpup = 0;
		run(1'b1, 8'h3c);
		check("crc_again", crc_ok_q, 1'b1);
		check("prog_again", prog_seen, 1'b1);
	endtask
	initial begin
		repeat (20) @(negedge core_clk);
		rstn = 1;
		t_first;
		t_next;
		t_bad;
		t_again;
		check("reset_gap", r7_err, 1'b0);
		end_of_test;
	end
endmodule // tb
